// ==== dv/srsp_host.sv ====
// host model: sends query characters, collects reply characters
// assumes 8 data bits, no parity, 1 stop, bit time of DIV core clocks
`timescale 1ns/10ps
`default_nettype none
module srsp_host #(
    parameter int DIV = 260
) (
    input  wire logic i_clk,
    input  wire logic i_line,
    output var logic  o_line
);
    initial o_line = 1'b1;
    task automatic put(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= f[i];
            repeat (DIV) @(posedge i_clk);
        end
    endtask : put
    task automatic get(output logic [7:0] b);
        int n;
        n = 0;
        b = 8'h00;
        // bounded: a silent device must not hang the host
        while (i_line !== 1'b0 && n < 20000) begin
            @(posedge i_clk);
            n++;
        end
        repeat (DIV / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge i_clk);
            b[i] = i_line;
        end
        repeat (DIV) @(posedge i_clk);
    endtask : get
endmodule : srsp_host
`default_nettype wire

// ==== dv/srsp_top_properties.sv ====
// checker: bus answer timing and serial line shape of the slave port
// assumes binding onto srsp_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module srsp_top_properties (
    input wire logic                   i_core_clk,
    input wire logic                   i_rst_n,
    input wire logic                   i_rxd,
    input wire srsp_pkg::srsp_wb_req_t i_wb,
    input wire logic                   o_wb_ack,
    input wire logic [31:0]            o_wb_dat,
    input wire logic                   o_txd,
    input wire logic                   o_tx_oe
);
    import srsp_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic req;
    assign req = i_wb.cyc & i_wb.stb & !o_wb_ack;
    sequence bit_edge; o_tx_oe && $changed(o_txd); endsequence
    // shortest bit is far above 8 cycles
    sequence bit_hold; $stable(o_txd)[*8]; endsequence
    wb_answer_a: assert property (req |=> o_wb_ack)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    ctrl_upper_a: assert property (req && !i_wb.we && i_wb.adr == ADR_CTRL |=> o_wb_dat[31:16] == 16'h0000)
        else $error("ctrl upper half not zero");
    unmapped_zero_a: assert property (req && !i_wb.we && i_wb.adr[7:6] == 2'h2 |=> o_wb_dat == 32'h0)
        else $error("unmapped read not zero");
    idle_mark_a: assert property (!o_tx_oe |-> o_txd)
        else $error("line not at mark while idle");
    start_space_a: assert property ($rose(o_tx_oe) |=> !o_txd)
        else $error("reply does not open with space");
    bit_time_a: assert property (bit_edge |=> bit_hold)
        else $error("bit shorter than a bit time");
    stop_mark_a: assert property ($fell(o_tx_oe) |-> $past(o_txd))
        else $error("reply not closed by stop bit");
endmodule : srsp_top_properties
bind srsp_top srsp_top_properties i_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rxd(i_rxd),
    .i_wb(i_wb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .o_txd(o_txd), .o_tx_oe(o_tx_oe));
`default_nettype wire

// ==== dv/test_serial_register_slave_port.sv ====
// bench: register bus, modbus exception reply and single register write
// assumes srsp_top, host model srsp_host, 10 mhz core clock
`timescale 1ns/10ps
`default_nettype none
module test_serial_register_slave_port;
    import srsp_pkg::*;
    logic         clk;
    logic         rst_n;
    logic         rxd;
    logic         txd;
    logic         oe;
    logic         ack;
    logic [31:0]  rdat;
    srsp_wb_req_t wb;
    wire logic    line;
    int           bad_count;
    int           total_checks;
    int           seed;
    logic [31:0]  q;
    logic [15:0]  v;
    // pulled-up line seen by the host
    assign line = oe ? txd : 1'b1;
    srsp_top i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_rxd(rxd), .i_wb(wb), .o_wb_ack(ack),
        .o_wb_dat(rdat), .o_txd(txd), .o_tx_oe(oe));
    srsp_host #(.DIV(int'(DIV_38400))) i_host (.i_clk(clk), .i_line(line), .o_line(rxd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: no bus ack", $time);
        end
        r = rdat;
        wb <= '0;
    endtask : wbx
    function automatic logic [15:0] crc16(input logic [7:0] m[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (m[i]) begin
            c = c ^ {8'h00, m[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16
    task automatic xact(input logic [7:0] qm[$], input logic [7:0] rm[$]);
        logic [15:0] c;
        logic [7:0]  b;
        c = crc16(qm);
        qm.push_back(c[7:0]);
        qm.push_back(c[15:8]);
        c = crc16(rm);
        rm.push_back(c[7:0]);
        rm.push_back(c[15:8]);
        @(posedge clk);
        foreach (qm[i]) i_host.put(qm[i]);
        foreach (rm[i]) begin
            i_host.get(b);
            chk({24'h0, b}, {24'h0, rm[i]}, "reply byte");
        end
    endtask : xact
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (95000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        seed = 32'hfdcb;
        bad_count = 0;
        total_checks = 0;
        rst_n = 1'b0;
        wb = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wbx(1'b0, ADR_CTRL, 32'h0, q);
        chk(q, {16'h0, CTRL_RESET}, "ctrl reset");
        wbx(1'b1, ADR_CTRL, 32'h0000_0146, q);
        wbx(1'b1, ADR_STAT, 32'hffff_ffff, q);
        wbx(1'b0, ADR_STAT, 32'h0, q);
        chk(q, 32'h0, "stat read only");
        wbx(1'b0, 8'h90, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        v = 16'($random(seed));
        wbx(1'b1, 8'h54, {16'($random(seed)), v}, q);
        wbx(1'b0, 8'h54, 32'h0, q);
        chk(q, {16'h0, v}, "holding word 5");
        xact('{8'h01, 8'h2b}, '{8'h01, 8'hab, 8'h01});
        v = 16'({$random(seed)} % 32'h2710);
        xact('{8'h01, 8'h06, 8'h00, 8'h06, v[15:8], v[7:0]}, '{8'h01, 8'h06, 8'h00, 8'h06, v[15:8], v[7:0]});
        wbx(1'b0, 8'h58, 32'h0, q);
        chk(q, {16'h0, v}, "holding word 6");
        wbx(1'b0, ADR_STAT, 32'h0, q);
        chk(q, 32'h0000_0002, "frame counts");
        report_and_stop();
    end
endmodule : test_serial_register_slave_port
`default_nettype wire

// ==== inc/srsp_pkg.sv ====
// constants, carriers and state encodings of the serial register slave port
// assumes one 10 mhz core clock and a classic wishbone master
package srsp_pkg;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          BAUD_9600     = 9600;
    localparam int          BAUD_19200    = 19200;
    localparam int          BAUD_38400    = 38400;
    localparam logic [10:0] DIV_9600      = 11'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
    localparam logic [10:0] DIV_19200     = 11'((CLK_HZ + BAUD_19200 / 2) / BAUD_19200);
    localparam logic [10:0] DIV_38400     = 11'((CLK_HZ + BAUD_38400 / 2) / BAUD_38400);
    localparam logic [5:0]  RTU_GAP_BITS  = 6'h24;
    localparam logic [7:0]  ADR_CTRL      = 8'h00;
    localparam logic [7:0]  ADR_STAT      = 8'h04;
    localparam logic [1:0]  ADR_MEM_PAGE  = 2'h1;
    localparam logic [15:0] CTRL_RESET    = 16'h0144;
    localparam int          CB_BAUD       = 0;
    localparam int          CB_EIGHT      = 2;
    localparam int          CB_PAR        = 3;
    localparam int          CB_STOP2      = 5;
    localparam int          CB_MODBUS     = 6;
    localparam int          CB_ID         = 8;
    localparam logic [1:0]  PAR_ODD       = 2'h1;
    localparam logic [7:0]  FC_READ       = 8'h03;
    localparam logic [7:0]  FC_WRITE1     = 8'h06;
    localparam logic [7:0]  FC_DIAG       = 8'h08;
    localparam logic [7:0]  FC_WRITEN     = 8'h10;
    localparam logic [7:0]  FC_EXC_BIT    = 8'h80;
    localparam logic [7:0]  EXC_FUNC      = 8'h01;
    localparam logic [7:0]  EXC_ADDR      = 8'h02;
    localparam logic [7:0]  EXC_VALUE     = 8'h03;
    localparam logic [16:0] MB_ADR_MAX    = 17'h002ee;
    localparam logic [16:0] MB_EXEMPT_LO  = 17'h007d0;
    localparam logic [16:0] MB_EXEMPT_HI  = 17'h00bb7;
    localparam logic [15:0] MB_MAX_ITEMS  = 16'h0008;
    localparam logic [15:0] MB_RO_LAST    = 16'h0003;
    localparam logic [15:0] MB_VAL_MAX    = 16'h270f;
    localparam logic [15:0] MB_NREGS      = 16'h0010;
    localparam logic [5:0]  RXBUF_BYTES   = 6'h20;
    localparam logic [15:0] CRC_INIT      = 16'hffff;
    localparam logic [15:0] CRC_POLY      = 16'ha001;
    localparam logic [7:0]  CH_STX        = 8'h02;
    localparam logic [7:0]  CH_ETX        = 8'h03;
    localparam logic [7:0]  CH_ACK        = 8'h06;
    localparam logic [7:0]  CH_NAK        = 8'h15;

    typedef enum logic [2:0] {ST_RX = 3'h1, ST_EVAL = 3'h2, ST_TX = 3'h4} srsp_main_t;
    typedef enum logic [1:0] {LN_IDLE = 2'h1, LN_BUSY = 2'h2} srsp_line_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } srsp_wb_req_t;
endpackage : srsp_pkg

// ==== rtl/srsp_top.sv ====
// serial register slave port: uart framing, modbus rtu slave, ascii block check
// assumes a classic wishbone master on i_core_clk and an rs-485 style driver enable
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - bit rate 9600, 19200 or 38400 selectable
// - start, 7/8 data, parity, 1/2 stop
// - parity none/odd/even, generated and checked
// - eight data bits force no parity
// - switch selects ascii or modbus engine
// - ascii link control: stx, etx, bcc
// - ascii characters are 7-bit codes
// - ascii checks char parity and bcc
// - register protocol uses binary rtu framing
// - function 03h reads consecutive registers
// - function 06h writes one register
// - function 08h echoes the query
// - function 10h writes consecutive registers
// - unsupported function gives exception 1
// - write to read-only gives exception 2
// - address out of range gives exception 2
// - value out of range gives exception 3
// - too many items gives exception 3
module srsp_top (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_n,
    input  wire logic                   i_rxd,
    input  wire srsp_pkg::srsp_wb_req_t i_wb,
    output logic                        o_wb_ack,
    output logic [31:0]                 o_wb_dat,
    output logic                        o_txd,
    output logic                        o_tx_oe
);
    import srsp_pkg::*;

    typedef struct packed {
        logic [15:0]        ctrl;
        logic [7:0]         n_good;
        logic [7:0]         n_crc;
        logic [7:0]         n_err;
        logic               wb_ack;
        logic [31:0]        wb_dat;
        logic               rx_s1;
        logic               rx_s2;
        srsp_line_t         rxs;
        logic [10:0]        rx_cnt;
        logic [3:0]         rx_idx;
        logic [7:0]         rx_sh;
        logic               rx_perr;
        logic [10:0]        gap_cnt;
        logic [5:0]         gap_bits;
        srsp_main_t         ms;
        logic [31:0][7:0]   rbuf;
        logic [5:0]         rlen;
        logic               rovf;
        logic               rbad;
        logic [15:0]        rcrc;
        logic               asc_in;
        logic               asc_last;
        logic [7:0]         bcc;
        logic [15:0][15:0]  mem;
        logic [7:0]         exc;
        logic [5:0]         tlen;
        logic [5:0]         tidx;
        logic               crc_on;
        logic [15:0]        tcrc;
        srsp_line_t         txs;
        logic [10:0]        tx_cnt;
        logic [3:0]         tx_idx;
        logic [11:0]        tx_sh;
        logic               txd;
        logic               tx_oe;
    } srsp_st_t;

    srsp_st_t    s;
    srsp_st_t    next_s;
    logic [10:0] div;
    logic [3:0]  nd;
    logic [3:0]  tx_total;
    logic        eight;
    logic        par_en;
    logic        odd;
    logic        modbus;
    logic [7:0]  my_id;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    function automatic logic in_rng(input logic [16:0] x);
        return (x <= MB_ADR_MAX) || ((x >= MB_EXEMPT_LO) && (x <= MB_EXEMPT_HI));
    endfunction : in_rng

    // addresses in range but beyond the implemented words read as zero
    function automatic logic [15:0] mem_rd(input srsp_st_t t, input logic [15:0] x);
        return (x < MB_NREGS) ? t.mem[x[3:0]] : 16'h0000;
    endfunction : mem_rd

    function automatic logic [7:0] resp(input srsp_st_t t, input logic [5:0] idx);
        logic [5:0]  off;
        logic [15:0] w;
        off = 6'(idx - 6'h03);
        w = mem_rd(t, 16'({t.rbuf[2], t.rbuf[3]} + {11'h000, off[5:1]}));
        if (!t.crc_on || (t.exc != 8'h00 && idx >= 6'h02)) begin
            return t.exc;
        end else if (t.exc != 8'h00) begin
            return (idx == 6'h00) ? t.rbuf[0] : (t.rbuf[1] | FC_EXC_BIT);
        end else if (t.rbuf[1] == FC_READ && idx >= 6'h02) begin
            return (idx == 6'h02) ? {t.rbuf[5][6:0], 1'b0} : (off[0] ? w[7:0] : w[15:8]);
        end
        return t.rbuf[idx[4:0]];
    endfunction : resp

    // changing the line settings mid-character garbles only that character
    assign eight    = s.ctrl[CB_EIGHT];
    assign par_en   = !eight && (s.ctrl[CB_PAR+1:CB_PAR] != 2'h0);
    assign odd      = s.ctrl[CB_PAR+1:CB_PAR] == PAR_ODD;
    assign modbus   = s.ctrl[CB_MODBUS];
    assign my_id    = s.ctrl[CB_ID+7:CB_ID];
    assign nd       = eight ? 4'h8 : 4'h7;
    assign tx_total = 4'(4'h2 + nd + {3'h0, par_en} + {3'h0, s.ctrl[CB_STOP2]});
    assign div      = (s.ctrl[CB_BAUD+1:CB_BAUD] == 2'h0) ? DIV_9600 :
                      (s.ctrl[CB_BAUD+1:CB_BAUD] == 2'h1) ? DIV_19200 : DIV_38400;

    always_comb begin
        logic        byte_ok;
        logic        byte_perr;
        logic [7:0]  byte_v;
        logic [7:0]  fc;
        logic [15:0] a;
        logic [15:0] c;
        logic [16:0] last;
        logic        vbad;
        logic        tx_go;
        logic [7:0]  tx_b;
        byte_ok   = 1'b0;
        byte_perr = 1'b0;
        byte_v    = 8'h00;
        fc        = s.rbuf[1];
        a         = {s.rbuf[2], s.rbuf[3]};
        c         = {s.rbuf[4], s.rbuf[5]};
        last      = 17'({1'b0, a} + {1'b0, c} - 17'h00001);
        vbad      = 1'b0;
        tx_go     = 1'b0;
        tx_b      = 8'h00;
        next_s    = s;
        // receive line: idle mark, start space, sample at mid bit
        next_s.rx_s1 = i_rxd;
        next_s.rx_s2 = s.rx_s1;
        case (s.rxs)
            LN_IDLE: begin
                if (!s.rx_s2) begin
                    next_s.rxs     = LN_BUSY;
                    next_s.rx_cnt  = div >> 1;
                    next_s.rx_idx  = 4'h0;
                    next_s.rx_sh   = 8'h00;
                    next_s.rx_perr = 1'b0;
                end
            end
            LN_BUSY: begin
                if (s.rx_cnt != 11'h000) begin
                    next_s.rx_cnt = 11'(s.rx_cnt - 11'h001);
                end else begin
                    next_s.rx_cnt = 11'(div - 11'h001);
                    next_s.rx_idx = 4'(s.rx_idx + 4'h1);
                    if (s.rx_idx == 4'h0) begin
                        next_s.rxs = s.rx_s2 ? LN_IDLE : LN_BUSY; // glitch, not a start bit
                    end else if (s.rx_idx <= nd) begin
                        next_s.rx_sh = {s.rx_s2, s.rx_sh[7:1]};
                    end else if (par_en && s.rx_idx == 4'(nd + 4'h1)) begin
                        next_s.rx_perr = (^s.rx_sh) ^ s.rx_s2 ^ odd;
                    end else begin
                        next_s.rxs = LN_IDLE;
                        byte_ok    = 1'b1;
                        byte_perr  = s.rx_perr | !s.rx_s2;
                        byte_v     = eight ? s.rx_sh : {1'b0, s.rx_sh[7:1]};
                    end
                end
            end
            default: next_s.rxs = LN_IDLE;
        endcase
        next_s.n_err = 8'(s.n_err + {7'h00, byte_ok && byte_perr});

        // silence timer for the end of an rtu frame, in bit times
        if (s.rxs == LN_BUSY || byte_ok) begin
            next_s.gap_cnt  = 11'h000;
            next_s.gap_bits = 6'h00;
        end else if (s.gap_cnt >= 11'(div - 11'h001)) begin
            next_s.gap_cnt  = 11'h000;
            next_s.gap_bits = (s.gap_bits == RTU_GAP_BITS) ? s.gap_bits : 6'(s.gap_bits + 6'h01);
        end else begin
            next_s.gap_cnt = 11'(s.gap_cnt + 11'h001);
        end

        case (s.ms)
            ST_RX: begin
                if (modbus) begin
                    if (byte_ok) begin
                        next_s.rbad = s.rbad | byte_perr;
                        next_s.rcrc = crc_step(s.rcrc, byte_v);
                        next_s.rovf = s.rovf | (s.rlen >= RXBUF_BYTES);
                        if (s.rlen < RXBUF_BYTES) begin
                            next_s.rbuf[s.rlen[4:0]] = byte_v;
                            next_s.rlen = 6'(s.rlen + 6'h01);
                        end
                    end else if (s.rlen != 6'h00 && s.gap_bits == RTU_GAP_BITS) begin
                        next_s.ms = ST_EVAL;
                    end
                end else if (byte_ok) begin
                    // ascii block: stx, text, etx, then bcc over text and etx
                    if (!s.asc_in) begin
                        if (byte_v[6:0] == CH_STX[6:0]) begin
                            next_s.asc_in   = 1'b1;
                            next_s.asc_last = 1'b0;
                            next_s.bcc      = 8'h00;
                            next_s.rbad     = byte_perr;
                        end
                    end else if (s.asc_last) begin
                        next_s.asc_in = 1'b0;
                        next_s.exc    = (!s.rbad && !byte_perr && byte_v == s.bcc) ? CH_ACK : CH_NAK;
                        next_s.crc_on = 1'b0;
                        next_s.tlen   = 6'h01;
                        next_s.tidx   = 6'h00;
                        next_s.tx_oe  = 1'b1;
                        next_s.ms     = ST_TX;
                    end else begin
                        next_s.bcc  = s.bcc ^ byte_v;
                        next_s.rbad = s.rbad | byte_perr;
                        if (byte_v[6:0] == CH_ETX[6:0]) begin
                            next_s.asc_last = 1'b1;
                        end
                    end
                end
            end
            ST_EVAL: begin
                next_s.ms   = ST_RX;
                next_s.rlen = 6'h00;
                next_s.rovf = 1'b0;
                next_s.rbad = 1'b0;
                next_s.rcrc = CRC_INIT;
                next_s.exc  = 8'h00;
                if (s.rlen < 6'h04 || s.rcrc != 16'h0000 || s.rovf || s.rbad) begin
                    next_s.n_crc = 8'(s.n_crc + 8'h01);
                end else if (s.rbuf[0] == my_id) begin
                    next_s.n_good = 8'(s.n_good + 8'h01);
                    for (int k = 0; k < 8; k++) begin
                        vbad = vbad | (16'(k) < c && {s.rbuf[7+2*k], s.rbuf[8+2*k]} > MB_VAL_MAX);
                    end
                    case (fc)
                        FC_READ: begin
                            if (c == 16'h0000 || c > MB_MAX_ITEMS) begin
                                next_s.exc = EXC_VALUE;
                            end else if (!in_rng({1'b0, a}) || !in_rng(last)) begin
                                next_s.exc = EXC_ADDR;
                            end
                            next_s.tlen = 6'(6'h03 + {c[4:0], 1'b0});
                        end
                        FC_WRITE1: begin
                            if (!in_rng({1'b0, a})) begin
                                next_s.exc = EXC_ADDR;
                            end else if (a <= MB_RO_LAST) begin
                                next_s.exc = EXC_ADDR;
                            end else if (c > MB_VAL_MAX) begin
                                next_s.exc = EXC_VALUE;
                            end else if (a < MB_NREGS) begin
                                next_s.mem[a[3:0]] = c;
                            end
                            next_s.tlen = 6'h06;
                        end
                        FC_DIAG: next_s.tlen = 6'(s.rlen - 6'h02);
                        FC_WRITEN: begin
                            if (c == 16'h0000 || c > MB_MAX_ITEMS) begin
                                next_s.exc = EXC_VALUE;
                            end else if (!in_rng({1'b0, a}) || !in_rng(last)) begin
                                next_s.exc = EXC_ADDR;
                            end else if (a <= MB_RO_LAST) begin
                                next_s.exc = EXC_ADDR;
                            end else if (vbad) begin
                                next_s.exc = EXC_VALUE;
                            end else begin
                                for (int k = 0; k < 8; k++) begin
                                    if (16'(k) < c && 16'(a + 16'(k)) < MB_NREGS) begin
                                        next_s.mem[4'(a + 16'(k))] = {s.rbuf[7+2*k], s.rbuf[8+2*k]};
                                    end
                                end
                            end
                            next_s.tlen = 6'h06;
                        end
                        default: next_s.exc = EXC_FUNC;
                    endcase
                    if (next_s.exc != 8'h00) begin
                        next_s.tlen = 6'h03;
                    end
                    next_s.crc_on = 1'b1;
                    next_s.tidx   = 6'h00;
                    next_s.tcrc   = CRC_INIT;
                    next_s.tx_oe  = 1'b1;
                    next_s.ms     = ST_TX;
                end
            end
            ST_TX: begin
                // half duplex: received characters are dropped while replying
                if (s.txs == LN_IDLE) begin
                    tx_go = (s.tidx < s.tlen) || (s.crc_on && s.tidx <= 6'(s.tlen + 6'h01));
                    tx_b  = (s.tidx < s.tlen) ? resp(s, s.tidx) :
                            (s.tidx == s.tlen) ? s.tcrc[7:0] : s.tcrc[15:8];
                    if (s.crc_on && s.tidx < s.tlen) begin
                        next_s.tcrc = crc_step(s.tcrc, tx_b);
                    end
                    if (tx_go) begin
                        next_s.tidx = 6'(s.tidx + 6'h01);
                    end else begin
                        next_s.tx_oe = 1'b0;
                        next_s.ms    = ST_RX;
                    end
                end
            end
            default: next_s.ms = ST_RX;
        endcase

        // transmit line: stop bits are the ones loaded above the data, idle drives the line high
        case (s.txs)
            LN_IDLE: begin
                next_s.txd = 1'b1;
                if (tx_go) begin
                    next_s.txs    = LN_BUSY;
                    next_s.txd    = 1'b0;
                    next_s.tx_cnt = 11'(div - 11'h001);
                    next_s.tx_idx = 4'h1;
                    next_s.tx_sh  = eight ? {4'hf, tx_b} :
                                    {4'hf, par_en ? ((^tx_b[6:0]) ^ odd) : 1'b1, tx_b[6:0]};
                end
            end
            LN_BUSY: begin
                if (s.tx_cnt != 11'h000) begin
                    next_s.tx_cnt = 11'(s.tx_cnt - 11'h001);
                end else if (s.tx_idx == tx_total) begin
                    next_s.txs = LN_IDLE;
                    next_s.txd = 1'b1;
                end else begin
                    next_s.tx_cnt = 11'(div - 11'h001);
                    next_s.tx_idx = 4'(s.tx_idx + 4'h1);
                    next_s.txd    = s.tx_sh[0];
                    next_s.tx_sh  = {1'b1, s.tx_sh[11:1]};
                end
            end
            default: next_s.txs = LN_IDLE;
        endcase

        // wishbone slave: ack one cycle after the request, write at the ack edge
        next_s.wb_ack = i_wb.cyc && i_wb.stb && !s.wb_ack;
        if (next_s.wb_ack) begin
            next_s.wb_dat = (i_wb.adr == ADR_CTRL) ? {16'h0000, s.ctrl} :
                            (i_wb.adr == ADR_STAT) ? {8'h00, s.n_err, s.n_crc, s.n_good} :
                            (i_wb.adr[7:6] == ADR_MEM_PAGE) ? {16'h0000, s.mem[i_wb.adr[5:2]]} : 32'h0000_0000;
        end
        if (s.wb_ack && i_wb.cyc && i_wb.stb && i_wb.we) begin
            for (int b = 0; b < 2; b++) begin
                if (i_wb.sel[b] && i_wb.adr == ADR_CTRL) begin
                    next_s.ctrl[8*b +: 8] = i_wb.dat[8*b +: 8];
                end
                if (i_wb.sel[b] && i_wb.adr[7:6] == ADR_MEM_PAGE) begin
                    next_s.mem[i_wb.adr[5:2]][8*b +: 8] = i_wb.dat[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s       <= '0;
            s.ctrl  <= CTRL_RESET;
            s.rx_s1 <= 1'b1;
            s.rx_s2 <= 1'b1;
            s.rxs   <= LN_IDLE;
            s.txs   <= LN_IDLE;
            s.ms    <= ST_RX;
            s.rcrc  <= CRC_INIT;
            s.txd   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign o_wb_ack = s.wb_ack;
    assign o_wb_dat = s.wb_dat;
    assign o_txd    = s.txd;
    assign o_tx_oe  = s.tx_oe;
endmodule : srsp_top
`default_nettype wire
